/* rtl/burst4_sram_dev.sv */
// memory end: burst-of-four ddr read and late-write ports over flops
`timescale 1ns/100ps
`default_nettype none
module burst4_sram_dev #(
  parameter int DW = burst4_sram_pkg::DATA_W,
  parameter int NB = burst4_sram_pkg::BYTE_N,
  parameter int AW = burst4_sram_pkg::ADDR_W
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // link
  burst4_sram_if.dev link,
  // status
  output logic o_rd_busy,
  output logic o_wr_busy
);
  import burst4_sram_pkg::*;
  localparam int BW = DW / NB;
  localparam int PS = RD_LAT_DLL + BURST;
  localparam int IW = 5 + AW + DW + NB;
  // link inputs at their idle levels, so no false edge follows reset
  localparam logic [IW-1:0] IN_IDLE = {5'h0e, {(AW + DW){1'b0}}, {NB{1'b1}}};
  ////////////////////////////////////////////////////////////////////////
  // input synchronisers and edge detection
  logic [IW-1:0] s1_r, s2_r;
  // k, k# and the write beat one cycle back: the value just before an edge
  logic [DW+NB+1:0] s3_r;
  logic k_s, kc_s, rd_n_s, wr_n_s, dll_s, edge_k, edge_kc, half;
  logic [AW-1:0] addr_s;
  logic [DW-1:0] wd_s;
  logic [NB-1:0] bwe_n_s;
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_r <= IN_IDLE;
      s2_r <= IN_IDLE;
      s3_r <= {2'h1, {DW{1'b0}}, {NB{1'b1}}};
    end else begin
      s1_r <= {link.k, link.k_n, link.read_n, link.write_n, link.dll_on,
               link.sync_addr_in, link.wdata, link.byte_write_enable_n};
      s2_r <= s1_r;
      s3_r <= {k_s, kc_s, s2_r[DW+NB-1:0]};
    end
  end
  assign {k_s, kc_s, rd_n_s, wr_n_s, dll_s, addr_s} = s2_r[IW-1:DW+NB];
  // the host launches the next beat on the very edge that samples this one
  assign {wd_s, bwe_n_s} = s3_r[DW+NB-1:0];
  assign edge_k = k_s & ~s3_r[DW+NB+1];
  assign edge_kc = kc_s & ~s3_r[DW+NB];
  assign half = edge_k | edge_kc;
  ////////////////////////////////////////////////////////////////////////
  // state
  logic [DW-1:0] mem_r [1<<AW], mem_nxt [1<<AW];
  logic [PS-1:0] pv_r, pv_nxt;
  logic [AW-1:0] pa_r [PS], pa_nxt [PS];
  logic [DW-1:0] q_r, q_nxt;
  logic qv_r, qv_nxt, echo_r, echo_nxt, wpend_r, wpend_nxt;
  wr_state_e wst_r, wst_nxt;
  logic [AW-1:0] wpa_r, wpa_nxt, wca_r, wca_nxt;
  logic [BURST-1:0][DW-1:0] wd_r, wd_nxt;
  logic [BURST-1:0][NB-1:0] wm_r, wm_nxt;
  logic [WBUF_N-1:0] bv_r, bv_nxt;
  logic [AW-1:0] ba_r [WBUF_N], ba_nxt [WBUF_N];
  logic [BURST-1:0][DW-1:0] bd_r [WBUF_N], bd_nxt [WBUF_N];
  logic [BURST-1:0][NB-1:0] bm_r [WBUF_N], bm_nxt [WBUF_N];

  ////////////////////////////////////////////////////////////////////////
  // read side: half-cycle pipeline, coherent lookup, echo clocks
  always_comb begin
    int lat;
    logic hit;
    logic [AW-1:0] ra, off;
    logic [DW-1:0] w;
    lat = dll_s ? RD_LAT_DLL : RD_LAT_BYP;
    hit = 1'b0;
    ra = '0;
    off = '0;
    w = '0;
    pv_nxt = pv_r;
    pa_nxt = pa_r;
    q_nxt = q_r;
    qv_nxt = qv_r;
    echo_nxt = echo_r;
    if (half) begin
      pv_nxt[0] = edge_k & ~rd_n_s;
      pa_nxt[0] = addr_s;
      for (int i = 1; i < PS; i++) begin
        pv_nxt[i] = pv_r[i-1];
        pa_nxt[i] = pa_r[i-1];
      end
      qv_nxt = 1'b0;
      for (int i = 0; i < PS; i++) begin
        if (pv_nxt[i] && i >= lat - 1 && i <= lat + 1) begin
          qv_nxt = 1'b1;
        end
        if (pv_nxt[i] && i >= lat && i <= lat + 3) begin
          hit = 1'b1;
          ra = pa_nxt[i] + AW'(i - lat);
        end
      end
      w = mem_r[ra];
      for (int s = WBUF_N - 1; s >= 0; s--) begin
        off = ra - ba_r[s];
        if (bv_r[s] && off < AW'(BURST)) begin
          for (int b = 0; b < NB; b++) begin
            if (bm_r[s][off[1:0]][b]) begin
              w[b*BW +: BW] = bd_r[s][off[1:0]][b*BW +: BW];
            end
          end
        end
      end
      if (hit) begin
        q_nxt = w;
      end
      echo_nxt = edge_k;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // write side: command, beat capture, late-write buffer, commit
  always_comb begin
    wst_nxt = wst_r;
    wpend_nxt = wpend_r;
    wpa_nxt = wpa_r;
    wca_nxt = wca_r;
    wd_nxt = wd_r;
    wm_nxt = wm_r;
    bv_nxt = bv_r;
    ba_nxt = ba_r;
    bd_nxt = bd_r;
    bm_nxt = bm_r;
    mem_nxt = mem_r;
    if (edge_k) begin
      unique case (wst_r)
        W_IDLE: begin
          if (wpend_r) begin
            wca_nxt = wpa_r;
            wd_nxt[0] = wd_s;
            wm_nxt[0] = ~bwe_n_s;
            wpend_nxt = 1'b0;
            wst_nxt = W_B2;
          end
        end
        W_B3: begin
          wd_nxt[2] = wd_s;
          wm_nxt[2] = ~bwe_n_s;
          wst_nxt = W_B4;
        end
        W_B2, W_B4: begin
        end
      endcase
      if (!wr_n_s) begin
        wpend_nxt = 1'b1;
        wpa_nxt = addr_s;
      end
    end else if (edge_kc) begin
      unique case (wst_r)
        W_B2: begin
          wd_nxt[1] = wd_s;
          wm_nxt[1] = ~bwe_n_s;
          wst_nxt = W_B3;
        end
        W_B4: begin
          wd_nxt[3] = wd_s;
          wm_nxt[3] = ~bwe_n_s;
          wst_nxt = W_IDLE;
          if (bv_r[WBUF_N-1]) begin
            for (int i = 0; i < BURST; i++) begin
              for (int b = 0; b < NB; b++) begin
                if (bm_r[WBUF_N-1][i][b]) begin
                  mem_nxt[ba_r[WBUF_N-1] + AW'(i)][b*BW +: BW] =
                    bd_r[WBUF_N-1][i][b*BW +: BW];
                end
              end
            end
          end
          for (int s = WBUF_N - 1; s > 0; s--) begin
            bv_nxt[s] = bv_r[s-1];
            ba_nxt[s] = ba_r[s-1];
            bd_nxt[s] = bd_r[s-1];
            bm_nxt[s] = bm_r[s-1];
          end
          bv_nxt[0] = 1'b1;
          ba_nxt[0] = wca_r;
          bd_nxt[0] = wd_nxt;
          bm_nxt[0] = wm_nxt;
        end
        W_IDLE, W_B3: begin
        end
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pv_r <= '0;
      pa_r <= '{default: '0};
      q_r <= '0;
      qv_r <= 1'b0;
      echo_r <= 1'b0;
      wst_r <= W_IDLE;
      wpend_r <= 1'b0;
      wpa_r <= '0;
      wca_r <= '0;
      wd_r <= '0;
      wm_r <= '0;
      bv_r <= '0;
      ba_r <= '{default: '0};
      bd_r <= '{default: '0};
      bm_r <= '{default: '0};
    end else begin
      pv_r <= pv_nxt;
      pa_r <= pa_nxt;
      q_r <= q_nxt;
      qv_r <= qv_nxt;
      echo_r <= echo_nxt;
      wst_r <= wst_nxt;
      wpend_r <= wpend_nxt;
      wpa_r <= wpa_nxt;
      wca_r <= wca_nxt;
      wd_r <= wd_nxt;
      wm_r <= wm_nxt;
      bv_r <= bv_nxt;
      ba_r <= ba_nxt;
      bd_r <= bd_nxt;
      bm_r <= bm_nxt;
    end
  end
  // array contents are not reset
  always_ff @(posedge i_sys_clk) begin
    mem_r <= mem_nxt;
  end
  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign link.q = q_r;
  assign link.output_valid_flag = qv_r;
  assign link.echo_true = echo_r;
  assign link.echo_comp = ~echo_r;
  assign o_rd_busy = |pv_r;
  assign o_wr_busy = (wst_r != W_IDLE) | wpend_r;
endmodule
`default_nettype wire

/* shared/burst4_sram_pkg.sv */
// constants shared by both ends of the burst-of-four memory link
`default_nettype none
package burst4_sram_pkg;
  // data, byte lane and address sizes
  localparam int DATA_W = 18;
  localparam int BYTE_N = 2;
  localparam int ADDR_W = 8;
  localparam int BURST = 4;
  // system clock and link clock timing
  localparam int SYS_PERIOD_NS = 40;
  localparam int K_PERIOD_NS = 320;
  localparam int K_DIV = K_PERIOD_NS / SYS_PERIOD_NS;
  // read latency in link half cycles, dll running and dll bypassed
  localparam int RD_LAT_DLL = 5;
  localparam int RD_LAT_BYP = 2;
  // write buffer depth in whole bursts
  localparam int WBUF_N = 2;
  // device write-side states
  typedef enum logic [3:0] {
    W_IDLE = 4'h1,
    W_B2 = 4'h2,
    W_B3 = 4'h4,
    W_B4 = 4'h8
  } wr_state_e;
  // controller write-side states
  typedef enum logic [4:0] {
    HW_IDLE = 5'h01,
    HW_CMD = 5'h02,
    HW_B2 = 5'h04,
    HW_B3 = 5'h08,
    HW_B4 = 5'h10
  } host_wr_e;
endpackage
`default_nettype wire

/* shared/burst4_sram_if.sv */
// link between the memory controller end and the memory end
`timescale 1ns/100ps
`default_nettype none
interface burst4_sram_if #(
  parameter int DW = burst4_sram_pkg::DATA_W,
  parameter int NB = burst4_sram_pkg::BYTE_N,
  parameter int AW = burst4_sram_pkg::ADDR_W
) ();
  logic k;
  logic k_n;
  logic read_n;
  logic write_n;
  logic [AW-1:0] sync_addr_in;
  logic [DW-1:0] wdata;
  logic [NB-1:0] byte_write_enable_n;
  logic dll_on;
  logic [DW-1:0] q;
  logic echo_true;
  logic echo_comp;
  logic output_valid_flag;

  modport host (
    output k, k_n, read_n, write_n, sync_addr_in, wdata,
    output byte_write_enable_n, dll_on,
    input q, echo_true, echo_comp, output_valid_flag
  );
  modport dev (
    input k, k_n, read_n, write_n, sync_addr_in, wdata,
    input byte_write_enable_n, dll_on,
    output q, echo_true, echo_comp, output_valid_flag
  );
endinterface
`default_nettype wire

/* rtl/burst4_sram_host.sv */
// controller end: clock pair, command spacing, write beats, read capture
`timescale 1ns/100ps
`default_nettype none
module burst4_sram_host #(
  parameter int DW = burst4_sram_pkg::DATA_W,
  parameter int NB = burst4_sram_pkg::BYTE_N,
  parameter int AW = burst4_sram_pkg::ADDR_W,
  parameter int KDIV = burst4_sram_pkg::K_DIV
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // link
  burst4_sram_if.host link,
  // read requests
  input wire logic i_rd_valid,
  input wire logic [AW-1:0] i_rd_addr,
  output logic o_rd_ready,
  // write requests, beat i at [i*DW +: DW], mask high writes a byte
  input wire logic i_wr_valid,
  input wire logic [AW-1:0] i_wr_addr,
  input wire logic [4*DW-1:0] i_wr_data,
  input wire logic [4*NB-1:0] i_wr_mask,
  output logic o_wr_ready,
  // mode
  input wire logic i_dll_on,
  // read data
  output logic [DW-1:0] o_rd_data,
  output logic o_rd_valid,
  output logic [1:0] o_rd_beat
);
  import burst4_sram_pkg::*;

  localparam int CW = $clog2(KDIV);

  ////////////////////////////////////////////////////////////////////////
  // clock divider and command launch
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic k_r, k_nxt;
  logic pt_a;
  logic pt_b;
  logic rd_gap_r, rd_gap_nxt;
  logic rd_go;
  logic wr_go;
  logic rd_n_r, rd_n_nxt;
  logic wr_n_r, wr_n_nxt;
  logic [AW-1:0] addr_r, addr_nxt;
  logic [DW-1:0] wd_r, wd_nxt;
  logic [NB-1:0] bwe_n_r, bwe_n_nxt;
  logic dll_r;
  host_wr_e hw_r, hw_nxt;
  logic wnext_r, wnext_nxt;
  logic [4*DW-1:0] pdat_r, pdat_nxt, wdat_r, wdat_nxt;
  logic [4*NB-1:0] pmsk_r, pmsk_nxt, wmsk_r, wmsk_nxt;

  // pt_a: k falls next, pt_b: k rises next
  assign pt_a = cnt_r == CW'(KDIV / 2 - 1);
  assign pt_b = cnt_r == CW'(KDIV - 1);
  assign o_rd_ready = pt_a & ~rd_gap_r;
  assign rd_go = o_rd_ready & i_rd_valid;
  assign o_wr_ready = pt_a & ~rd_go & ((hw_r == HW_IDLE) | (hw_r == HW_B3));
  assign wr_go = o_wr_ready & i_wr_valid;

  always_comb begin
    cnt_nxt = pt_b ? '0 : cnt_r + 1'b1;
    k_nxt = pt_b ? 1'b1 : (pt_a ? 1'b0 : k_r);
    rd_gap_nxt = rd_gap_r;
    rd_n_nxt = rd_n_r;
    wr_n_nxt = wr_n_r;
    addr_nxt = addr_r;
    wd_nxt = wd_r;
    bwe_n_nxt = bwe_n_r;
    hw_nxt = hw_r;
    wnext_nxt = wnext_r;
    pdat_nxt = pdat_r;
    pmsk_nxt = pmsk_r;
    wdat_nxt = wdat_r;
    wmsk_nxt = wmsk_r;
    if (pt_a) begin
      // read or write command for next k rise
      rd_gap_nxt = rd_go;
      rd_n_nxt = ~rd_go;
      wr_n_nxt = ~wr_go;
      if (rd_go) begin
        addr_nxt = i_rd_addr;
      end else if (wr_go) begin
        addr_nxt = i_wr_addr;
      end
      if (wr_go) begin
        pdat_nxt = i_wr_data;
        pmsk_nxt = i_wr_mask;
      end
    end
    unique case (hw_r)
      HW_IDLE: begin
        if (wr_go) begin
          hw_nxt = HW_CMD;
        end
      end
      HW_CMD: begin
        // beat one at next k rise
        if (pt_a) begin
          wdat_nxt = pdat_r;
          wmsk_nxt = pmsk_r;
          wd_nxt = pdat_r[0 +: DW];
          bwe_n_nxt = ~pmsk_r[0 +: NB];
          hw_nxt = HW_B2;
        end
      end
      HW_B2: begin
        if (pt_b) begin
          wd_nxt = wdat_r[DW +: DW];
          bwe_n_nxt = ~wmsk_r[NB +: NB];
          hw_nxt = HW_B3;
        end
      end
      HW_B3: begin
        if (pt_a) begin
          wd_nxt = wdat_r[2*DW +: DW];
          bwe_n_nxt = ~wmsk_r[2*NB +: NB];
          wnext_nxt = wr_go;
          hw_nxt = HW_B4;
        end
      end
      HW_B4: begin
        if (pt_b) begin
          wd_nxt = wdat_r[3*DW +: DW];
          bwe_n_nxt = ~wmsk_r[3*NB +: NB];
          wnext_nxt = 1'b0;
          hw_nxt = wnext_r ? HW_CMD : HW_IDLE;
        end
      end
      default: begin
        hw_nxt = HW_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r <= '0;
      k_r <= 1'b0;
      rd_gap_r <= 1'b0;
      rd_n_r <= 1'b1;
      wr_n_r <= 1'b1;
      addr_r <= '0;
      wd_r <= '0;
      bwe_n_r <= '1;
      dll_r <= 1'b0;
      hw_r <= HW_IDLE;
      wnext_r <= 1'b0;
      pdat_r <= '0;
      pmsk_r <= '0;
      wdat_r <= '0;
      wmsk_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
      k_r <= k_nxt;
      rd_gap_r <= rd_gap_nxt;
      rd_n_r <= rd_n_nxt;
      wr_n_r <= wr_n_nxt;
      addr_r <= addr_nxt;
      wd_r <= wd_nxt;
      bwe_n_r <= bwe_n_nxt;
      dll_r <= i_dll_on;
      hw_r <= hw_nxt;
      wnext_r <= wnext_nxt;
      pdat_r <= pdat_nxt;
      pmsk_r <= pmsk_nxt;
      wdat_r <= wdat_nxt;
      wmsk_r <= wmsk_nxt;
    end
  end

  assign link.k = k_r;
  assign link.k_n = ~k_r;
  assign link.read_n = rd_n_r;
  assign link.write_n = wr_n_r;
  assign link.sync_addr_in = addr_r;
  assign link.wdata = wd_r;
  assign link.byte_write_enable_n = bwe_n_r;
  assign link.dll_on = dll_r;

  ////////////////////////////////////////////////////////////////////////
  // read capture on the four echo edges after the valid window opens, the last two after it closes
  logic [DW+2:0] s1_r, s2_r;
  logic et_d_r, ec_d_r;
  logic echo_edge;
  logic seen_r, seen_nxt;
  logic [1:0] hb_r, hb_nxt;
  logic [DW-1:0] rdat_r, rdat_nxt;
  logic rval_r, rval_nxt;
  logic [1:0] rbeat_r, rbeat_nxt;

  assign echo_edge = (s2_r[DW+2] & ~et_d_r) | (s2_r[DW+1] & ~ec_d_r);

  always_comb begin
    seen_nxt = seen_r;
    hb_nxt = hb_r;
    rdat_nxt = rdat_r;
    rval_nxt = 1'b0;
    rbeat_nxt = rbeat_r;
    if (echo_edge) begin
      // four beats from the window start
      if (hb_r != 2'h0 || seen_r) begin
        rdat_nxt = s2_r[DW-1:0];
        rval_nxt = 1'b1;
        rbeat_nxt = hb_r;
        hb_nxt = hb_r + 2'h1;
      end
      seen_nxt = s2_r[DW];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      // echo pair idles with the complement high
      s1_r <= {3'h2, {DW{1'b0}}};
      s2_r <= {3'h2, {DW{1'b0}}};
      et_d_r <= 1'b0;
      ec_d_r <= 1'b1;
      seen_r <= 1'b0;
      hb_r <= 2'h0;
      rdat_r <= '0;
      rval_r <= 1'b0;
      rbeat_r <= 2'h0;
    end else begin
      s1_r <= {link.echo_true, link.echo_comp, link.output_valid_flag, link.q};
      s2_r <= s1_r;
      et_d_r <= s2_r[DW+2];
      ec_d_r <= s2_r[DW+1];
      seen_r <= seen_nxt;
      hb_r <= hb_nxt;
      rdat_r <= rdat_nxt;
      rval_r <= rval_nxt;
      rbeat_r <= rbeat_nxt;
    end
  end

  assign o_rd_data = rdat_r;
  assign o_rd_valid = rval_r;
  assign o_rd_beat = rbeat_r;
endmodule
`default_nettype wire

/* dv/burst4_sram_asserts.sv */
// assertions on the link between the controller end and the memory end
`timescale 1ns/100ps
`default_nettype none
module burst4_sram_asserts (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // link
  input wire logic k,
  input wire logic k_n,
  input wire logic read_n,
  input wire logic write_n,
  input wire logic dll_on,
  input wire logic [burst4_sram_pkg::DATA_W-1:0] q,
  input wire logic echo_true,
  input wire logic echo_comp,
  input wire logic output_valid_flag
);
  import burst4_sram_pkg::*;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  //////////////////////////////////////////////////////////////////////////
  // cycles since the last command of each kind, saturating
  logic read_n_r;
  logic write_n_r;
  logic [4:0] rd_gap_r;
  logic [4:0] rd_gap_nxt;
  logic [4:0] wr_gap_r;
  logic [4:0] wr_gap_nxt;
  always_comb begin
    rd_gap_nxt = (rd_gap_r == 5'h1f) ? rd_gap_r : rd_gap_r + 5'h01;
    wr_gap_nxt = (wr_gap_r == 5'h1f) ? wr_gap_r : wr_gap_r + 5'h01;
    if (read_n_r && !read_n) begin
      rd_gap_nxt = 5'h01;
    end
    if (write_n_r && !write_n) begin
      wr_gap_nxt = 5'h01;
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      read_n_r <= 1'b1;
      write_n_r <= 1'b1;
      rd_gap_r <= 5'h1f;
      wr_gap_r <= 5'h1f;
    end else begin
      read_n_r <= read_n;
      write_n_r <= write_n;
      rd_gap_r <= rd_gap_nxt;
      wr_gap_r <= wr_gap_nxt;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  sequence rd_cmd_s;
    $fell(read_n);
  endsequence
  sequence vld_hold_s;
    output_valid_flag [*8] ##1 output_valid_flag [*4];
  endsequence
  echo_pair_a: assert property (echo_comp != echo_true)
    else $error("echo pair not complementary");
  k_pair_a: assert property (k_n != k)
    else $error("link clock pair not complementary");
  echo_run_a: assert property (1'b1 |-> ##[1:16] $changed(echo_true))
    else $error("echo clock stopped");
  rd_gap_a: assert property ($fell(read_n) |-> rd_gap_r >= 5'h10)
    else $error("reads closer than two link cycles");
  wr_gap_a: assert property ($fell(write_n) |-> wr_gap_r >= 5'h10)
    else $error("writes closer than two link cycles");
  cmd_on_k_a: assert property (($fell(read_n) || $fell(write_n))
    |-> ##[3:5] $rose(k)) else $error("command not met by link clock rise");
  rd_lat_dll_a: assert property (rd_cmd_s ##0 dll_on
    |-> ##[20:28] $rose(output_valid_flag)) else $error("read latency off");
  rd_lat_byp_a: assert property (rd_cmd_s ##0 !dll_on
    |-> ##[8:16] $rose(output_valid_flag)) else $error("bypass latency off");
  vld_len_a: assert property ($rose(output_valid_flag)
    |-> vld_hold_s ##1 !output_valid_flag) else $error("valid window length");
  q_on_echo_a: assert property ($changed(q) |-> $changed(echo_true))
    else $error("read beat not on echo edge");
endmodule
`default_nettype wire

/* dv/test_quad_port_burst4_sram_protocol.sv */
// self-checking bench joining the controller end and the memory end
`timescale 1ns/100ps
`default_nettype none
module test_quad_port_burst4_sram_protocol;
  import burst4_sram_pkg::*;
  localparam int BW = DATA_W / BYTE_N;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic rd_valid = 1'b0;
  logic [ADDR_W-1:0] rd_addr = 8'h00;
  logic rd_ready;
  logic wr_valid = 1'b0;
  logic [ADDR_W-1:0] wr_addr = 8'h00;
  logic [4*DATA_W-1:0] wr_data = 72'h0;
  logic [4*BYTE_N-1:0] wr_mask = 8'h00;
  logic wr_ready;
  logic dll_en = 1'b1;
  logic [DATA_W-1:0] rd_data;
  logic rd_dv;
  logic [1:0] rd_beat;
  logic rd_busy;
  logic wr_busy;
  logic [DATA_W-1:0] exp_mem [256];
  logic [DATA_W-1:0] exp_q [$];
  logic [DATA_W-1:0] got_q [$];
  int bad_count = 0;
  int n_checks = 0;
  int n_beat = 0;
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end
  //////////////////////////////////////////////////////////////////////////
  burst4_sram_if u_burst4_sram_if ();
  burst4_sram_dev u_burst4_sram_dev (.i_sys_clk(sys_clk), .i_rst_n(rst_n),
    .link(u_burst4_sram_if), .o_rd_busy(rd_busy), .o_wr_busy(wr_busy));
  burst4_sram_host u_burst4_sram_host (.i_sys_clk(sys_clk), .i_rst_n(rst_n),
    .link(u_burst4_sram_if), .i_rd_valid(rd_valid), .i_rd_addr(rd_addr),
    .o_rd_ready(rd_ready), .i_wr_valid(wr_valid), .i_wr_addr(wr_addr),
    .i_wr_data(wr_data), .i_wr_mask(wr_mask), .o_wr_ready(wr_ready),
    .i_dll_on(dll_en), .o_rd_data(rd_data), .o_rd_valid(rd_dv),
    .o_rd_beat(rd_beat));
  burst4_sram_asserts u_burst4_sram_asserts (.i_sys_clk(sys_clk),
    .i_rst_n(rst_n), .k(u_burst4_sram_if.k), .k_n(u_burst4_sram_if.k_n),
    .read_n(u_burst4_sram_if.read_n), .write_n(u_burst4_sram_if.write_n),
    .dll_on(u_burst4_sram_if.dll_on), .q(u_burst4_sram_if.q),
    .echo_true(u_burst4_sram_if.echo_true),
    .echo_comp(u_burst4_sram_if.echo_comp),
    .output_valid_flag(u_burst4_sram_if.output_valid_flag));
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] seen,
      input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s exp %h seen %h", name, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d bad %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  function automatic logic [4*DATA_W-1:0] pat(input logic [7:0] s);
    for (int i = 0; i < 4; i++) begin
      pat[i*DATA_W +: DATA_W] = {s, 8'(i), 2'(i) ^ 2'h2};
    end
  endfunction
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // read beats are taken at the falling edge, where they are settled
  always @(negedge sys_clk) begin
    if (rd_dv === 1'b1) begin
      chk("beat index", 32'(rd_beat), 32'(n_beat % 4));
      n_beat++;
      got_q.push_back(rd_data);
    end
  end
  task automatic rd_req(input logic [ADDR_W-1:0] a, input logic last);
    int n;
    rd_valid = 1'b1;
    rd_addr = a;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (rd_ready !== 1'b1 && n < 64);
    chk("rd taken", 32'(rd_ready), 32'h1);
    for (int i = 0; i < 4; i++) begin
      exp_q.push_back(exp_mem[a + 8'(i)]);
    end
    @(posedge sys_clk);
    #1;
    if (last) begin
      rd_valid = 1'b0;
    end
  endtask
  task automatic wr_req(input logic [ADDR_W-1:0] a,
      input logic [4*DATA_W-1:0] d, input logic [4*BYTE_N-1:0] m,
      input logic last);
    int n;
    wr_valid = 1'b1;
    wr_addr = a;
    wr_data = d;
    wr_mask = m;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (wr_ready !== 1'b1 && n < 64);
    chk("wr taken", 32'(wr_ready), 32'h1);
    for (int i = 0; i < 4; i++) begin
      for (int b = 0; b < BYTE_N; b++) begin
        if (m[i*BYTE_N+b]) begin
          exp_mem[a + 8'(i)][b*BW +: BW] = d[i*DATA_W+b*BW +: BW];
        end
      end
    end
    @(posedge sys_clk);
    #1;
    if (last) begin
      wr_valid = 1'b0;
    end
  endtask
  task automatic drain(input string name);
    int n;
    n = 0;
    while (got_q.size() < exp_q.size() && n < 400) begin
      @(negedge sys_clk);
      n++;
    end
    chk("beat count", 32'(got_q.size()), 32'(exp_q.size()));
    while (exp_q.size() > 0 && got_q.size() > 0) begin
      chk("rd data", 32'(got_q.pop_front()), 32'(exp_q.pop_front()));
    end
    exp_q.delete();
    got_q.delete();
    idle(16);
    chk("rd busy", 32'(rd_busy), 32'h0);
    chk("wr busy", 32'(wr_busy), 32'h0);
    $display("test %s done", name);
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic t_basic();
    wr_req(8'h10, pat(8'ha1), 8'hff, 1'b1);
    idle(28);
    rd_req(8'h10, 1'b1);
    drain("basic");
  endtask
  // back-to-back writes push the 0x10 burst from t_basic out to the array
  task automatic t_commit();
    wr_req(8'h20, pat(8'hb2), 8'hff, 1'b0);
    wr_req(8'h30, pat(8'hc3), 8'hff, 1'b1);
    idle(28);
    rd_req(8'h10, 1'b0);
    rd_req(8'h20, 1'b0);
    rd_req(8'h30, 1'b1);
    drain("commit");
  endtask
  task automatic t_mask();
    wr_req(8'h20, pat(8'hd4), 8'h93, 1'b0);
    wr_req(8'h30, pat(8'he5), 8'h00, 1'b1);
    idle(28);
    rd_req(8'h20, 1'b0);
    rd_req(8'h30, 1'b1);
    drain("mask");
  endtask
  // read overlaps the write beats; the burst wraps past the top
  task automatic t_wrap();
    wr_req(8'hfe, pat(8'hf6), 8'hff, 1'b1);
    rd_req(8'h20, 1'b1);
    idle(28);
    rd_req(8'hfe, 1'b1);
    drain("wrap");
  endtask
  task automatic t_bypass();
    dll_en = 1'b0;
    idle(16);
    rd_req(8'h10, 1'b1);
    drain("bypass");
    dll_en = 1'b1;
    idle(16);
  endtask
  initial begin
    #800000;
    bad_count++;
    summarize();
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    idle(1);
    t_basic();
    t_commit();
    t_mask();
    t_wrap();
    t_bypass();
    summarize();
  end
endmodule
`default_nettype wire
